// file: common/bbs_pkg.sv
// Constants, field layouts and carrier types for the bus number and
// downstream status register bank. Assumes a single 200 MHz clock domain.
// ============================================================
// Functional notes
// - Tenure timer bits 31:27 writable, 26:24 zero
// - Timer sets least downstream master tenure
// - Subordinate bus number, read/write, resets zero
// - Secondary bus match converts Type 1 to 0
// - Primary bus number, read/write, resets zero
// - Parity fault flag on three parity cases
// - System fault flag on fault pin low
// - Master abort received flag, write-one clear
// - Target abort received flag, write-one clear
// - Target abort signaled flag, write-one clear
// - Select timing reads 01, medium decode
// - Master data fault flag, write-one clear
// - Back-to-back capable bit reads one
// - Fast clock capable bit reads one
// - I/O upper bound bits 15:12, low FFF
// - I/O lower bound bits 7:4, low zero
// - I/O capability fields read 0x1
package bbs_pkg;

    // ============================================================
    // Register map
    localparam logic [11:0] BBS_OFS_BUSNUM  = 12'h018;
    localparam logic [11:0] BBS_OFS_STATUS  = 12'h01c;
    localparam logic [11:0] BBS_OFS_IRQ_EN  = 12'h040;
    localparam logic [11:0] BBS_OFS_IRQ_ST  = 12'h044;

    // ============================================================
    // Field positions
    localparam int BBS_TMR_LSB     = 27;
    localparam int BBS_SUB_LSB     = 16;
    localparam int BBS_SEC_LSB     = 8;
    localparam int BBS_PRI_LSB     = 0;
    localparam int BBS_FLG_PE      = 31;
    localparam int BBS_FLG_SERR    = 30;
    localparam int BBS_FLG_RMA     = 29;
    localparam int BBS_FLG_RTA     = 28;
    localparam int BBS_FLG_STA     = 27;
    localparam int BBS_FLG_MDF     = 24;
    localparam int BBS_IOU_LSB     = 12;
    localparam int BBS_IOL_LSB     = 4;

    // Fixed status bits: select timing 01, b2b, 66 MHz, I/O caps 0x1
    localparam logic [31:0] BBS_STATUS_FIXED = 32'h02a0_0101;
    localparam logic [31:0] BBS_W1C_MASK     = 32'hf900_0000;
    localparam logic [4:0]  BBS_TMR_RST      = 5'h00;
    localparam logic [7:0]  BBS_BUS_RST      = 8'h00;
    localparam logic [3:0]  BBS_IO_RST       = 4'h0;
    localparam logic [11:0] BBS_IO_LOW_ONES  = 12'hfff;
    localparam logic [11:0] BBS_IO_LOW_ZERO  = 12'h000;
    localparam int          BBS_TMR_STEP_SH  = 3;
    localparam int          BBS_NFLAG        = 6;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bbs_req_t;

    // Downstream event inputs, one pulse per event in sys_clk domain
    typedef struct packed {
        logic addr_parity_tgt;
        logic data_parity_tgt_wr;
        logic data_parity_mst_rd;
        logic master_abort;
        logic target_abort_rx;
        logic target_abort_tx;
        logic master_data_fault;
    } bbs_evt_t;

    typedef struct packed {
        logic [7:0] bus;
        logic       valid;
    } bbs_cfg_req_t;

    typedef struct packed {
        logic claim;
        logic to_type0;
    } bbs_cfg_ans_t;

endpackage

// file: hw/bbs_regs.sv
// Bus number, tenure timer, downstream status and I/O window registers.
// Assumes a plain register port, events as one-cycle pulses on sys_clk,
// and the fault pin and downstream clock arriving asynchronously.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module bbs_regs #(
    parameter int TMR_W = 5
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire bbs_pkg::bbs_req_t     req,
    output logic [31:0]                rdata,
    input  wire bbs_pkg::bbs_evt_t     evt,
    input  wire logic                  downstream_system_fault_pin_n,
    input  wire logic                  ds_clk,
    input  wire logic                  ds_master_busy,
    output logic                       tenure_expired,
    input  wire bbs_pkg::bbs_cfg_req_t cfg_req,
    output bbs_pkg::bbs_cfg_ans_t      cfg_ans,
    input  wire logic [31:0]           io_addr,
    output logic                       io_forward,
    output logic                       irq
);
    import bbs_pkg::*;

    // ============================================================
    // Storage
    logic [TMR_W-1:0] tenure_r;
    logic [7:0]       sub_bus_r;
    logic [7:0]       sec_bus_r;
    logic [7:0]       pri_bus_r;
    logic [3:0]       io_upper_r;
    logic [3:0]       io_lower_r;
    logic [BBS_NFLAG-1:0] flag_r;
    logic [BBS_NFLAG-1:0] flag_nxt;
    logic [BBS_NFLAG-1:0] irq_en_r;
    logic [31:0]      rdata_r;

    // ============================================================
    // Decode
    wire logic wr_bus  = req.wr && (req.addr == BBS_OFS_BUSNUM);
    wire logic wr_stat = req.wr && (req.addr == BBS_OFS_STATUS);
    wire logic wr_ien  = req.wr && (req.addr == BBS_OFS_IRQ_EN);
    wire logic wr_ist  = req.wr && (req.addr == BBS_OFS_IRQ_ST);

    // ============================================================
    // Synchronisers for asynchronous pins
    logic serr_s1_r;
    logic serr_s2_r;
    logic dclk_s1_r;
    logic dclk_s2_r;
    logic dclk_d_r;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            serr_s1_r <= 1'b1;
            serr_s2_r <= 1'b1;
            dclk_s1_r <= 1'b0;
            dclk_s2_r <= 1'b0;
            dclk_d_r  <= 1'b0;
        end else begin
            serr_s1_r <= downstream_system_fault_pin_n;
            serr_s2_r <= serr_s1_r;
            dclk_s1_r <= ds_clk;
            dclk_s2_r <= dclk_s1_r;
            dclk_d_r  <= dclk_s2_r;
        end
    end
    wire logic ds_edge = dclk_s2_r && !dclk_d_r;

    // ============================================================
    // Status flags; index order PE,SERR,RMA,RTA,STA,MDF
    wire logic [BBS_NFLAG-1:0] flag_set = {
        evt.addr_parity_tgt | evt.data_parity_tgt_wr
            | evt.data_parity_mst_rd,
        !serr_s2_r,
        evt.master_abort,
        evt.target_abort_rx,
        evt.target_abort_tx,
        evt.master_data_fault
    };
    wire logic [BBS_NFLAG-1:0] flag_wclr = {
        req.wdata[BBS_FLG_PE], req.wdata[BBS_FLG_SERR],
        req.wdata[BBS_FLG_RMA], req.wdata[BBS_FLG_RTA],
        req.wdata[BBS_FLG_STA], req.wdata[BBS_FLG_MDF]
    };
    wire logic [BBS_NFLAG-1:0] flag_clr =
        (wr_stat || wr_ist) ? flag_wclr : '0;

    // Set beats clear so a same-cycle event is never lost
    always_comb begin
        flag_nxt = (flag_r & ~flag_clr) | flag_set;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flag_r   <= '0;
            irq_en_r <= '0;
        end else begin
            flag_r <= flag_nxt;
            if (wr_ien) begin
                irq_en_r <= flag_wclr;
            end
        end
    end

    assign irq = |(flag_r & irq_en_r);

    // ============================================================
    // Writable fields
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tenure_r   <= BBS_TMR_RST;
            sub_bus_r  <= BBS_BUS_RST;
            sec_bus_r  <= BBS_BUS_RST;
            pri_bus_r  <= BBS_BUS_RST;
            io_upper_r <= BBS_IO_RST;
            io_lower_r <= BBS_IO_RST;
        end else begin
            if (wr_bus) begin
                tenure_r  <= req.wdata[BBS_TMR_LSB +: TMR_W];
                sub_bus_r <= req.wdata[BBS_SUB_LSB +: 8];
                sec_bus_r <= req.wdata[BBS_SEC_LSB +: 8];
                pri_bus_r <= req.wdata[BBS_PRI_LSB +: 8];
            end
            if (wr_stat) begin
                io_upper_r <= req.wdata[BBS_IOU_LSB +: 4];
                io_lower_r <= req.wdata[BBS_IOL_LSB +: 4];
            end
        end
    end

    // ============================================================
    // Read mux; low timer bits and reserved bits read zero
    wire logic [31:0] rd_bus = {tenure_r, 3'b000, sub_bus_r,
                                sec_bus_r, pri_bus_r};
    wire logic [31:0] flag_word = {flag_r[5], flag_r[4], flag_r[3],
                                   flag_r[2], flag_r[1], 2'b00,
                                   flag_r[0], 24'h000000};
    // Fixed bits: select timing, b2b, 66 MHz, capabilities
    wire logic [31:0] rd_stat = flag_word | BBS_STATUS_FIXED
        | {16'h0000, io_upper_r, 4'h0,
           io_lower_r, 4'h0};
    wire logic [31:0] rd_irq_w = {flag_r[5], flag_r[4], flag_r[3],
                                  flag_r[2], flag_r[1], 2'b00,
                                  flag_r[0], 24'h000000};
    wire logic [31:0] rd_ien_w = {irq_en_r[5], irq_en_r[4], irq_en_r[3],
                                  irq_en_r[2], irq_en_r[1], 2'b00,
                                  irq_en_r[0], 24'h000000};
    wire logic [31:0] rd_sel =
        (req.addr == BBS_OFS_BUSNUM) ? rd_bus   :
        (req.addr == BBS_OFS_STATUS) ? rd_stat  :
        (req.addr == BBS_OFS_IRQ_EN) ? rd_ien_w :
        (req.addr == BBS_OFS_IRQ_ST) ? rd_irq_w : 32'h0000_0000;

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= req.rd ? rd_sel : 32'h0000_0000;
        end
    end
    assign rdata = rdata_r;

    // ============================================================
    // Tenure timer: counts downstream clock edges while mastering
    logic [TMR_W+2:0] tcnt_r;
    wire logic [TMR_W+2:0] tenure_cycles =
        (TMR_W+3)'({tenure_r, 3'b000});
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tcnt_r <= '0;
        end else if (!ds_master_busy) begin
            tcnt_r <= '0;
        end else if (ds_edge && tcnt_r < tenure_cycles) begin
            tcnt_r <= tcnt_r + (TMR_W+3)'(1);
        end
    end
    // Ownership may be kept at least this long before yielding
    assign tenure_expired = ds_master_busy
                         && (tcnt_r >= tenure_cycles);

    // ============================================================
    // Type 1 configuration routing
    wire logic bus_in_range = cfg_req.valid
        && (cfg_req.bus >= sec_bus_r) && (cfg_req.bus <= sub_bus_r);
    assign cfg_ans.claim    = bus_in_range;
    assign cfg_ans.to_type0 = bus_in_range
                           && (cfg_req.bus == sec_bus_r);

    // ============================================================
    // I/O window, 16-bit decode
    wire logic [15:0] io_lo = {io_lower_r, BBS_IO_LOW_ZERO};
    wire logic [15:0] io_hi = {io_upper_r, BBS_IO_LOW_ONES};
    assign io_forward = (io_addr[31:16] == 16'h0000)
                     && (io_addr[15:0] >= io_lo)
                     && (io_addr[15:0] <= io_hi);

endmodule

// file: tb/bbs_checker.sv
// Assertions on the ports of bbs_regs.
// Assumes one sys_clk domain; bound to bbs_regs below.
`timescale 1ns/1ps
module bbs_checker #(
    parameter int TMR_W = 5
) (
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    input wire bbs_pkg::bbs_req_t     req,
    input wire logic [31:0]           rdata,
    input wire bbs_pkg::bbs_evt_t     evt,
    input wire logic                  ds_master_busy,
    input wire logic                  tenure_expired,
    input wire bbs_pkg::bbs_cfg_req_t cfg_req,
    input wire bbs_pkg::bbs_cfg_ans_t cfg_ans,
    input wire logic [31:0]           io_addr,
    input wire logic                  io_forward,
    input wire logic                  irq
);
    import bbs_pkg::*;
    // ====
    // Shadows of the writable fields
    logic [31:0] bus_r;
    logic [31:0] en_r;
    logic [3:0]  up_r;
    logic [3:0]  lo_r;
    logic        w_bus;
    logic        w_st;
    logic        w_en;
    assign w_bus = req.wr && req.addr == BBS_OFS_BUSNUM;
    assign w_st = req.wr && req.addr == BBS_OFS_STATUS;
    assign w_en = req.wr && req.addr == BBS_OFS_IRQ_EN;
    always_ff @(posedge sys_clk) begin
        bus_r <= !resetn ? 32'h0 : w_bus ? req.wdata & 32'hf8ff_ffff : bus_r;
        en_r <= !resetn ? 32'h0 : w_en ? req.wdata & BBS_W1C_MASK : en_r;
        up_r <= !resetn ? 4'h0 : w_st ? req.wdata[15:12] : up_r;
        lo_r <= !resetn ? 4'h0 : w_st ? req.wdata[7:4] : lo_r;
    end
    // ====
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle_zero: assert property (
        !$past(req.rd) |-> rdata == 32'h0) else $error("rdata not zero");
    a_status_fixed_bits: assert property (
        $past(req.rd) && $past(req.addr) == BBS_OFS_STATUS
        |-> (rdata & 32'h06ff_0f0f) == BBS_STATUS_FIXED) else $error("fixed");
    a_busnum_readback: assert property (
        $past(req.rd) && $past(req.addr) == BBS_OFS_BUSNUM
        |-> rdata == bus_r) else $error("bus number readback");
    a_claim_range: assert property (
        cfg_req.valid |-> cfg_ans.claim == (cfg_req.bus >= bus_r[15:8]
        && cfg_req.bus <= bus_r[23:16])) else $error("claim range");
    a_type0_convert: assert property (
        cfg_req.valid |-> cfg_ans.to_type0 == (cfg_ans.claim
        && cfg_req.bus == bus_r[15:8])) else $error("type0 convert");
    a_io_window_fwd: assert property (
        io_forward == (io_addr[31:16] == 16'h0
        && io_addr[15:0] >= {lo_r, 12'h000}
        && io_addr[15:0] <= {up_r, 12'hfff})) else $error("io window");
    a_tenure_idle_low: assert property (
        !ds_master_busy |-> !tenure_expired) else $error("tenure idle");
    a_abort_raises_irq: assert property (
        evt.master_abort && en_r[BBS_FLG_RMA] && !req.wr |=> irq)
        else $error("master abort irq");
    c_type0: cover property (cfg_ans.to_type0);
    c_io_fwd: cover property (io_forward);
    c_tenure: cover property (tenure_expired);
endmodule
bind bbs_regs bbs_checker #(.TMR_W(TMR_W)) u_chk (.sys_clk(sys_clk),
    .resetn(resetn), .req(req), .rdata(rdata), .evt(evt),
    .ds_master_busy(ds_master_busy), .tenure_expired(tenure_expired),
    .cfg_req(cfg_req), .cfg_ans(cfg_ans), .io_addr(io_addr),
    .io_forward(io_forward), .irq(irq));

// file: tb/bbs_far_side.sv
// Downstream side model: bus clock, fault pin and event pulses.
// Assumes sys_clk from the bench; events are sys_clk pulses.
`timescale 1ns/1ps
module bbs_far_side (
    input  wire logic         sys_clk,
    output logic              ds_clk,
    output logic              fault_n,
    output bbs_pkg::bbs_evt_t evt
);
    import bbs_pkg::*;
    // ====
    // Downstream bus clock runs free, phase unrelated
    initial begin
        ds_clk = 1'b0;
        fault_n = 1'b1;
        evt = '0;
        #7;
        forever #24 ds_clk = ~ds_clk;
    end
    task automatic pulse(input int i);
        @(posedge sys_clk);
        evt[i] <= 1'b1;
        @(posedge sys_clk);
        evt <= '0;
    endtask
    // Held low long enough to cross the synchronizer
    task automatic serr();
        @(posedge sys_clk);
        fault_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        fault_n <= 1'b1;
    endtask
endmodule

// file: tb/tb_bbs_regs.sv
// Self-checking bench for bbs_regs over its register port.
// Assumes bbs_far_side drives the downstream pins and events.
`timescale 1ns/1ps
module tb_bbs_regs;
    import bbs_pkg::*;
    localparam logic [31:0] S = 32'h02a0_5131;
    logic         sys_clk = 1'b0;
    logic         resetn = 1'b0;
    logic         busy = 1'b0;
    bbs_req_t     req = '0;
    bbs_cfg_req_t cfg_req = '0;
    logic [31:0]  io_addr = 32'h0;
    bbs_evt_t     evt;
    bbs_cfg_ans_t cfg_ans;
    logic [31:0]  rdata;
    logic         fault_n, ds_clk, expired, io_fwd, irq;
    int           bad_count = 0;
    int           tests_run = 0;
    logic [31:0]  fb [7] = '{32'h0100_0000, 32'h0800_0000, 32'h1000_0000,
        32'h2000_0000, 32'h8000_0000, 32'h8000_0000, 32'h8000_0000};
    logic [31:0]  ia [5] = '{32'h2fff, 32'h3000, 32'h5fff, 32'h6000,
        32'h1_3000};
    bbs_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .req(req),
        .rdata(rdata), .evt(evt), .downstream_system_fault_pin_n(fault_n),
        .ds_clk(ds_clk), .ds_master_busy(busy), .tenure_expired(expired),
        .cfg_req(cfg_req), .cfg_ans(cfg_ans), .io_addr(io_addr),
        .io_forward(io_fwd), .irq(irq));
    bbs_far_side u_far (.sys_clk(sys_clk), .ds_clk(ds_clk),
        .fault_n(fault_n), .evt(evt));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ====
    // Access and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ====
    // Sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(BBS_OFS_BUSNUM, 32'h0);
        rd(BBS_OFS_STATUS, BBS_STATUS_FIXED);
        rd(12'h050, 32'h0);
        wr(BBS_OFS_BUSNUM, '1);
        rd(BBS_OFS_BUSNUM, 32'hf8ff_ffff);
        wr(BBS_OFS_BUSNUM, 32'h0805_0301);
        for (int b = 1; b < 8; b++) begin
            @(posedge sys_clk);
            cfg_req <= '{bus: 8'(b), valid: 1'b1};
            #1 chk(cfg_ans, {b inside {[3:5]}, b == 3});
        end
        wr(BBS_OFS_STATUS, 32'hffff_5030);
        rd(BBS_OFS_STATUS, S);
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            io_addr <= ia[i];
            #1 chk(io_fwd, i == 1 || i == 2);
        end
        wr(BBS_OFS_IRQ_EN, '1);
        for (int i = 0; i < 7; i++) begin
            u_far.pulse(i);
            rd(BBS_OFS_STATUS, S | fb[i]);
            chk(irq, 1'b1);
            wr(BBS_OFS_STATUS, S);
            rd(BBS_OFS_STATUS, S | fb[i]);
            wr(BBS_OFS_STATUS, S | fb[i]);
            rd(BBS_OFS_STATUS, S);
            chk(irq, 1'b0);
        end
        fork
            u_far.pulse(3);
            wr(BBS_OFS_STATUS, S | fb[3]);
        join
        rd(BBS_OFS_STATUS, S | fb[3]);
        u_far.serr();
        rd(BBS_OFS_IRQ_ST, 32'h6000_0000);
        wr(BBS_OFS_IRQ_ST, '1);
        rd(BBS_OFS_STATUS, S);
        wr(BBS_OFS_IRQ_EN, 32'h0);
        u_far.pulse(0);
        rd(BBS_OFS_IRQ_ST, fb[0]);
        chk(irq, 1'b0);
        @(posedge sys_clk);
        busy <= 1'b1;
        repeat (50) @(posedge sys_clk);
        #1 chk(expired, 1'b0);
        repeat (60) @(posedge sys_clk);
        #1 chk(expired, 1'b1);
        @(posedge sys_clk);
        busy <= 1'b0;
        @(posedge sys_clk);
        #1 chk(expired, 1'b0);
        summarize();
    end
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
endmodule
